// *** design/tx_interpolation_gain_path.v ***
`timescale 1ns/1ns
`include "tx_path_defines.vh"
module tx_interpolation_gain_path (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        in_valid,
  input  wire [11:0] in_word,
  input  wire        tx_enable,
  input  wire        half_duplex,
  input  wire        half_duplex_pd_en,
  input  wire [5:0]  parallel_gain_port,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  output reg  [11:0] dac_word,
  output reg         dac_powered,
  output reg         current_output_amp_en,
  output reg  [2:0]  primary_gain,
  output reg  [2:0]  sec_stage1_gain,
  output reg  [2:0]  sec_stage2_gain,
  output reg  [2:0]  sec_stage3_gain,
  output reg  [2:0]  primary_offset_current,
  output reg  [2:0]  secondary_offset_current,
  output reg  [3:0]  dac_atten_code,
  output reg  [1:0]  amp_atten_code
);

  // Core clock is the DAC update clock; input words arrive on in_valid at input_word_rate.
  // Serial-port register images.
  reg [7:0]  tx_gain_q;
  reg [7:0]  gain_src_q;
  reg [7:0]  interp_q;
  reg [7:0]  route_q;
  reg [7:0]  mir_pri_q;
  reg [7:0]  mir_sec_q;
  reg [7:0]  off_q;
  reg [7:0]  pd_dly_q;
  // Parallel gain pins after the first and second synchroniser flop.
  reg [5:0]  pgp_s1_q;
  reg [5:0]  pgp_s2_q;
  // Half-duplex mode and power-down enable straps after each synchroniser flop.
  reg        hd_s1_q;
  reg        hd_s2_q;
  reg        hdpd_s1_q;
  reg        hdpd_s2_q;
  reg [11:0] hb1_line [0:`HB1_TAPS-1];
  reg [11:0] hb2_line [0:`HB2_TAPS-1];
  reg [11:0] hb1_out_q;
  reg [11:0] hb2_out_q;
  reg        hb1_phase_q;
  reg        hb2_phase_q;
  reg        hb1_vld_q;
  // Cycles left before a half-duplex power-down may take effect.
  reg [7:0]  drain_q;
  // Loop index for the filter lines.
  integer    i;

  // Symmetric half-band sum: centre tap at half weight plus two outer pairs.
  function [11:0] hb_mix;
    input [11:0] a;
    input [11:0] b;
    input [11:0] c;
    input [11:0] d;
    input [11:0] e;
    reg   [14:0] s;
    begin
      s = {{3{a[11]}}, a} * 15'sd4 + {{3{b[11]}}, b} * 15'd5 + {{3{c[11]}}, c} * 15'd5
        - {{3{d[11]}}, d} - {{3{e[11]}}, e};
      hb_mix = s[14:3];
    end
  endfunction

  // Write strobe for one register address; shared by every register process.
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  // Pair of parallel-port synchroniser flops; the pins are outside this clock.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pgp_s1_q <= 6'h00;
      pgp_s2_q <= 6'h00;
    end else begin
      pgp_s1_q <= parallel_gain_port;
      pgp_s2_q <= pgp_s1_q;
    end
  end

  // Mode straps come from pins outside this clock, so they pass two flops.
  // Both reset low, which keeps the DAC powered until the straps have settled.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hd_s1_q   <= 1'b0;
      hd_s2_q   <= 1'b0;
      hdpd_s1_q <= 1'b0;
      hdpd_s2_q <= 1'b0;
    end else begin
      hd_s1_q   <= half_duplex;
      hd_s2_q   <= hd_s1_q;
      hdpd_s1_q <= half_duplex_pd_en;
      hdpd_s2_q <= hdpd_s1_q;
    end
  end

  // Transmit gain; the parallel port wins while selected, so serial writes are refused then.
  // The port reloads every clock, which is why a serial write could never stick in that mode.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_gain_q <= `RST_ZERO;
    end else if (gain_src_q[`BIT_PORT_SEL]) begin
      tx_gain_q <= {tx_gain_q[7:6], pgp_s2_q};
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_TX_GAIN) && reg_wdata[`BIT_GAIN_EN]) begin
      tx_gain_q <= {2'h0, reg_wdata[5:0]};
    end
  end

  // Gain source select; bit 6 hands the gain register to the parallel pins.
  // Switching sources mid-burst may load one transitional code from the pins.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain_src_q <= `RST_ZERO;
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_GAIN_SOURCE)) begin
      gain_src_q <= reg_wdata;
    end
  end

  // Interpolation control; the factor code sits in the top two bits.
  // The reserved code is stored as written and silences the output instead.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interp_q <= `RST_ZERO;
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_INTERP_CTRL)) begin
      interp_q <= reg_wdata;
    end
  end

  // Output route; bit 0 takes the amplifier out of the path.
  // The DAC output itself is never gated by this register.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      route_q <= `RST_ZERO;
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_OUTPUT_ROUTE)) begin
      route_q <= reg_wdata;
    end
  end

  // Primary mirror register, which also carries the gain enable bit.
  // Its reset value is the one the composite gain mapping relies on.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mir_pri_q <= `RST_MIRROR_PRI;
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_MIRROR_PRI)) begin
      mir_pri_q <= reg_wdata;
    end
  end

  // Secondary mirror register for the second and third stages.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mir_sec_q <= `RST_MIRROR_SEC;
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_MIRROR_SEC)) begin
      mir_sec_q <= reg_wdata;
    end
  end

  // Offset current register; both sources are off after reset.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      off_q <= `RST_ZERO;
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_OFFSET_CUR)) begin
      off_q <= reg_wdata;
    end
  end

  // Power-down delay in update clocks.
  // Too small a value cuts the tail of a burst that is still in the filters.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pd_dly_q <= `RST_PD_DELAY;
    end else if (wr_hit(reg_wr, reg_addr, `ADDR_PD_DELAY)) begin
      pd_dly_q <= reg_wdata;
    end
  end

  // Read mux; gain readback needs the enable bit, unmapped addresses read zero.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      // Gain readback answers only when the read itself carries bit 6.
      case (reg_addr)
        `ADDR_TX_GAIN:      reg_rdata <= reg_wdata[`BIT_GAIN_EN] ? {2'h0, tx_gain_q[5:0]} : 8'h00;
        `ADDR_GAIN_SOURCE:  reg_rdata <= gain_src_q;
        `ADDR_INTERP_CTRL:  reg_rdata <= interp_q;
        `ADDR_OUTPUT_ROUTE: reg_rdata <= route_q;
        `ADDR_MIRROR_PRI:   reg_rdata <= mir_pri_q;
        `ADDR_MIRROR_SEC:   reg_rdata <= mir_sec_q;
        `ADDR_OFFSET_CUR:   reg_rdata <= off_q;
        `ADDR_PD_DELAY:     reg_rdata <= pd_dly_q;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // Mirror gains; defaults stay in force until the enable bit is set.
  // Clearing the enable bit later brings the defaults back without a rewrite.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      primary_gain    <= `DEF_PRI_GAIN;
      sec_stage1_gain <= `DEF_SEC_G1;
      sec_stage2_gain <= `DEF_SEC_G2;
      sec_stage3_gain <= `DEF_SEC_G3;
    end else if (mir_pri_q[`BIT_MIRROR_EN]) begin
      primary_gain    <= mir_pri_q[2:0];
      sec_stage1_gain <= mir_pri_q[6:4];
      sec_stage2_gain <= mir_sec_q[6:4];
      sec_stage3_gain <= mir_sec_q[2:0];
    end else begin
      primary_gain    <= `DEF_PRI_GAIN;
      sec_stage1_gain <= `DEF_SEC_G1;
      sec_stage2_gain <= `DEF_SEC_G2;
      sec_stage3_gain <= `DEF_SEC_G3;
    end
  end

  // Standing-current offsets; a zero code leaves that source off.
  // Most bursts want them off, since they only add amplifier current.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      primary_offset_current   <= 3'h0;
      secondary_offset_current <= 3'h0;
    end else begin
      primary_offset_current   <= off_q[2:0];
      secondary_offset_current <= off_q[6:4];
    end
  end

  // Amplifier enable follows the route bit and drops with DAC power-down.
  // The DAC pins stay driven either way; only the amplifier copy is gated.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      current_output_amp_en <= 1'b1;
    end else begin
      current_output_amp_en <= ~route_q[`BIT_AMP_OFF] & dac_powered;
    end
  end

  // DAC fine attenuation: the low four gain bits in 0.5 dB steps.
  // These bits are all that matters when the amplifier is out of the path.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dac_atten_code <= 4'h0;
    end else begin
      dac_atten_code <= tx_gain_q[3:0];
    end
  end

  // Amplifier coarse attenuation: the upper two gain bits in 6 dB steps.
  // Forced to zero with the amplifier off, so only four bits stay in use.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      amp_atten_code <= 2'h0;
    end else begin
      amp_atten_code <= route_q[`BIT_AMP_OFF] ? 2'h0 : tx_gain_q[5:4];
    end
  end

  // First stage: 43-tap line shifted at the input word rate, emitting two phases per word.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `HB1_TAPS; i = i + 1)
        hb1_line[i] <= 12'h000;
      hb1_out_q   <= 12'h000;
      hb1_phase_q <= 1'b0;
      hb1_vld_q   <= 1'b0;
    end else begin
      // Valid drops unless a phase is emitted on this clock.
      hb1_vld_q <= 1'b0;
      // A new word shifts the line and emits the even phase; the odd phase follows.
      if (in_valid) begin
        hb1_line[0] <= in_word;
        for (i = 1; i < `HB1_TAPS; i = i + 1)
          hb1_line[i] <= hb1_line[i-1];
        hb1_out_q   <= hb1_line[21];
        hb1_phase_q <= 1'b0;
        hb1_vld_q   <= 1'b1;
      end else if (!hb1_phase_q) begin
        hb1_out_q   <= hb_mix(hb1_line[20], hb1_line[20], hb1_line[21], hb1_line[19], hb1_line[22]);
        hb1_phase_q <= 1'b1;
        hb1_vld_q   <= 1'b1;
      end
    end
  end

  // Second stage: 11-tap line at twice the word rate, interpolating every update clock.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `HB2_TAPS; i = i + 1)
        hb2_line[i] <= 12'h000;
      hb2_out_q   <= 12'h000;
      hb2_phase_q <= 1'b0;
    end else begin
      // Each first-stage sample shifts the line; the clocks between emit the midpoint.
      if (hb1_vld_q) begin
        hb2_line[0] <= hb1_out_q;
        for (i = 1; i < `HB2_TAPS; i = i + 1)
          hb2_line[i] <= hb2_line[i-1];
        hb2_out_q   <= hb2_line[5];
        hb2_phase_q <= 1'b0;
      end else begin
        hb2_out_q   <= hb_mix(hb2_line[4], hb2_line[4], hb2_line[5], hb2_line[3], hb2_line[6]);
        hb2_phase_q <= ~hb2_phase_q;
      end
    end
  end

  // Output select by factor; the DAC takes one sample on every update clock.
  // Bypass is honoured only in half-duplex, where no filter latency is needed.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dac_word <= 12'h000;
    end else begin
      case (interp_q[7:6])
        `INTERP_X4: dac_word <= hb2_out_q;
        `INTERP_X2: dac_word <= hb1_out_q;
        `INTERP_X1: dac_word <= (in_valid && hd_s2_q) ? in_word : dac_word;
        default:    dac_word <= 12'h000;
      endcase
    end
  end

  // Drain counter that delays half-duplex power-down past the filter pipeline.
  // The count reloads whenever a burst is active, so a short gap never cuts power.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dac_powered <= 1'b1;
      drain_q     <= 8'h00;
    end else if (!hd_s2_q || !hdpd_s2_q || tx_enable) begin
      drain_q     <= pd_dly_q;
      dac_powered <= 1'b1;
    end else if (drain_q != 8'h00) begin
      drain_q <= drain_q - 8'h01;
    end else begin
      dac_powered <= 1'b0;
    end
  end

endmodule

// *** design/tx_path_defines.vh ***
`ifndef TX_PATH_DEFINES_VH
`define TX_PATH_DEFINES_VH
`define ADDR_TX_GAIN        8'h0A
`define ADDR_GAIN_SOURCE    8'h0B
`define ADDR_INTERP_CTRL    8'h0C
`define ADDR_OUTPUT_ROUTE   8'h0E
`define ADDR_MIRROR_PRI     8'h10
`define ADDR_MIRROR_SEC     8'h11
`define ADDR_OFFSET_CUR     8'h12
`define ADDR_PD_DELAY       8'h13
`define RST_MIRROR_PRI      8'h44
`define RST_MIRROR_SEC      8'h00
`define RST_ZERO            8'h00
`define RST_PD_DELAY        8'h30
`define INTERP_X4           2'h0
`define INTERP_X2           2'h1
`define INTERP_X1           2'h2
`define BIT_GAIN_EN         6
`define BIT_PORT_SEL        6
`define BIT_MIRROR_EN       7
`define BIT_AMP_OFF         0
`define DEF_PRI_GAIN        3'h4
`define DEF_SEC_G1          3'h4
`define DEF_SEC_G2          3'h4
`define DEF_SEC_G3          3'h2
`define HB1_TAPS            43
`define HB2_TAPS            11
`endif

// *** tb/baseband_source.sv ***
`timescale 1ns/1ns
module baseband_source (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        tx_enable,
  output logic       in_valid,
  output logic [11:0] in_word
);
  logic [1:0] phase_q;
  // One word every fourth clock suits every factor; between words the line inverts itself on every clock so stale data stands out.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q  <= 2'h0;
      in_valid <= 1'b0;
      in_word  <= 12'h000;
    end else begin
      phase_q  <= phase_q + 2'h1;
      in_valid <= tx_enable && phase_q == 2'h3;
      in_word  <= (tx_enable && phase_q == 2'h3) ? 12'($urandom) : ~in_word;
    end
  end
endmodule

// *** tb/tx_interpolation_gain_path_tb_top.sv ***
`timescale 1ns/1ns
module tx_interpolation_gain_path_tb_top;
  logic        core_clk = 0, rst = 1, tx_enable = 0, reg_wr = 0, reg_rd = 0, rd_pend = 0;
  logic        half_duplex = 1, half_duplex_pd_en = 1;
  logic        in_valid, dac_powered, current_output_amp_en;
  logic [11:0] in_word, dac_word, w;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, v;
  logic [5:0]  parallel_gain_port = 0;
  logic [2:0]  primary_gain, sec_stage1_gain, sec_stage2_gain, sec_stage3_gain;
  logic [2:0]  primary_offset_current, secondary_offset_current;
  logic [3:0]  dac_atten_code;
  logic [1:0]  amp_atten_code;
  logic [11:0] exp_q[$];
  int          bad_count = 0, comparisons = 0, n;
  always #5 core_clk = ~core_clk;
  tx_interpolation_gain_path i_dut (.core_clk, .rst, .in_valid, .in_word, .tx_enable, .half_duplex,
    .half_duplex_pd_en, .parallel_gain_port, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .dac_word,
    .dac_powered, .current_output_amp_en, .primary_gain, .sec_stage1_gain, .sec_stage2_gain, .sec_stage3_gain,
    .primary_offset_current, .secondary_offset_current, .dac_atten_code, .amp_atten_code);
  baseband_source i_src (.core_clk, .rst, .tx_enable, .in_valid, .in_word);
  task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk); #1 reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(posedge core_clk); #1 reg_wr = 0;
  endtask
  // Reads carry bit 6 so the gain register would answer too.
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(12'(e));
    @(posedge core_clk); #1 reg_rd = 1; reg_addr = a; reg_wdata = 8'h40;
    @(posedge core_clk); #1 reg_rd = 0;
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Read data is registered, so it is compared one edge after the request is taken.
  always @(posedge core_clk) begin
    if (rd_pend) check("reg_rdata", 12'(reg_rdata), exp_q.pop_front());
    rd_pend <= reg_rd;
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(46));
    repeat (4) @(posedge core_clk);
    #1 rst = 0;
    rd(8'h10, 8'h44); rd(8'h0E, 8'h00); rd(8'h13, 8'h30); rd(8'h20, 8'h00);
    check("pri_gain", 12'(primary_gain), 12'h004);
    check("sec_gains", 12'({sec_stage1_gain, sec_stage2_gain, sec_stage3_gain}), 12'h122);
    tx_enable = 1;
    for (n = 0; n < 3; n++) begin
      wr(8'h0C, 8'(n << 6));
      rd(8'h0C, 8'(n << 6));
    end
    n = 0;
    while (in_valid !== 1'b1 && n < 8) begin
      @(posedge core_clk); #1 n++;
    end
    w = in_word;
    @(posedge core_clk); #1 check("x1_bypass", dac_word, w);
    wr(8'h0C, 8'hC0);
    repeat (60) @(posedge core_clk);
    #1 check("dac_word", dac_word, 12'h000);
    wr(8'h0C, 8'h00);
    wr(8'h0E, 8'h01); settle; check("amp_en", 12'(current_output_amp_en), 12'h000);
    v = 8'h40 | 8'($urandom) & 8'h3F;
    wr(8'h0A, v); settle; check("dac_att", 12'(dac_atten_code), 12'(v[3:0]));
    check("amp_att_off", 12'(amp_atten_code), 12'h000);
    wr(8'h0E, 8'h00); settle; check("amp_en", 12'(current_output_amp_en), 12'h001);
    check("amp_att", 12'(amp_atten_code), 12'(v[5:4]));
    wr(8'h0A, v ^ 8'h4F); settle; check("dac_att_ign", 12'(dac_atten_code), 12'(v[3:0]));
    v = {1'b0, 3'($urandom % 5), 1'b0, 3'($urandom % 5)};
    wr(8'h10, v); settle; check("pri_def", 12'(primary_gain), 12'h004);
    v[7] = 1'b1;
    wr(8'h10, v); settle; check("pri_gain", 12'(primary_gain), 12'(v[2:0]));
    check("sec1", 12'(sec_stage1_gain), 12'(v[6:4]));
    v = {1'b0, 3'($urandom % 7), 1'b0, 3'($urandom % 6)};
    wr(8'h11, v); settle; check("sec23", 12'({sec_stage2_gain, sec_stage3_gain}), 12'({v[6:4], v[2:0]}));
    wr(8'h10, 8'h44);
    v = 8'($urandom) & 8'h77;
    wr(8'h12, v); settle;
    check("offsets", 12'({secondary_offset_current, primary_offset_current}), 12'({v[6:4], v[2:0]}));
    parallel_gain_port = 6'($urandom);
    wr(8'h0B, 8'h40); settle; settle;
    check("port_gain", 12'({amp_atten_code, dac_atten_code}), 12'(parallel_gain_port));
    rd(8'h0A, 8'(parallel_gain_port));
    wr(8'h0B, 8'h00);
    tx_enable = 0;
    n = 0;
    while (dac_powered === 1'b1 && n < 200) begin
      @(posedge core_clk); #1 n++;
    end
    check("pd_delay", 12'(n >= 46 && n <= 52), 12'h001);
    rst = 1;
    @(posedge core_clk); #1 rst = 0;
    rd(8'h10, 8'h44);
    check("pri_rst", 12'(primary_gain), 12'h004);
    give_verdict;
  end
endmodule

// *** tb/tx_path_monitor.sv ***
`timescale 1ns/1ns
module tx_path_monitor (
  input wire       core_clk,
  input wire       rst,
  input wire       tx_enable,
  input wire       half_duplex,
  input wire       half_duplex_pd_en,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       dac_powered,
  input wire       current_output_amp_en,
  input wire [2:0] primary_gain,
  input wire [2:0] sec_stage1_gain,
  input wire [2:0] sec_stage3_gain,
  input wire [2:0] primary_offset_current,
  input wire [2:0] secondary_offset_current,
  input wire [3:0] dac_atten_code,
  input wire [1:0] amp_atten_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Write strobes per register; writes reach the outputs two cycles after they are taken.
  wire wr_route = reg_wr && reg_addr == 8'h0E;
  wire wr_mir   = reg_wr && reg_addr == 8'h10;
  property p_amp_off; wr_route && reg_wdata[0] |-> ##2 !current_output_amp_en && amp_atten_code == 2'h0; endproperty
  a_amp_off: assert property (p_amp_off) else $error("amplifier left enabled");
  property p_mir_def; wr_mir && !reg_wdata[7] |-> ##2 primary_gain == 3'h4 && sec_stage1_gain == 3'h4; endproperty
  a_mir_def: assert property (p_mir_def) else $error("mirror defaults lost");
  property p_mir_set;
    wr_mir && reg_wdata[7] |-> ##2 primary_gain == $past(reg_wdata[2:0], 2) && sec_stage1_gain == $past(reg_wdata[6:4], 2);
  endproperty
  a_mir_set: assert property (p_mir_set) else $error("mirror gain not applied");
  property p_offset;
    reg_wr && reg_addr == 8'h12 |-> ##2 primary_offset_current == $past(reg_wdata[2:0], 2)
      && secondary_offset_current == $past(reg_wdata[6:4], 2);
  endproperty
  a_offset: assert property (p_offset) else $error("offset current wrong");
  property p_rst_def; $fell(rst) |-> primary_gain == 3'h4 && sec_stage3_gain == 3'h2 && dac_powered; endproperty
  a_rst_def: assert property (p_rst_def) else $error("reset defaults wrong");
  // The pipeline must drain before power goes, so power holds for a while after the burst.
  property p_pd_hold; $fell(tx_enable) && half_duplex && half_duplex_pd_en && dac_powered |=> dac_powered [*8]; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("powered down too early");
  property p_gain_ign; reg_wr && reg_addr == 8'h0A && !reg_wdata[6] |=> $stable(dac_atten_code) [*2]; endproperty
  a_gain_ign: assert property (p_gain_ign) else $error("gain write without enable took effect");
  property p_unmapped; reg_rd && reg_addr == 8'h20 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind tx_interpolation_gain_path tx_path_monitor i_mon (.core_clk, .rst, .tx_enable, .half_duplex, .half_duplex_pd_en,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .dac_powered, .current_output_amp_en, .primary_gain,
  .sec_stage1_gain, .sec_stage3_gain, .primary_offset_current, .secondary_offset_current, .dac_atten_code,
  .amp_atten_code);
